// ### logic/bus_and_timer_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none
module bus_and_timer_pin_mux
   import pin_mux_pkg::*;
(
   // clock and reset
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_b_i,
   // register port
   input  wire logic [REG_AW-1:0]    reg_addr_i,
   input  wire logic [REG_DW-1:0]    reg_wdata_i,
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   output logic      [REG_DW-1:0]    reg_rdata_o,
   // external bus controller side
   input  wire logic [23:0]          ext_addr_i,
   input  wire logic [31:16]         ext_wdata_i,
   input  wire logic                 ext_data_drive_i,
   output logic      [31:16]         ext_rdata_o,
   // peripheral outputs
   input  wire logic [3:0]           timer_out_i,
   input  wire logic [7:0]           compare_out_i,
   input  wire logic [5:0]           pulse_out_i,
   // data bus mid byte pins
   input  wire logic [7:0]           ext_data_mid_byte_pins_i,
   output logic      [7:0]           ext_data_mid_byte_pins_o,
   output logic      [7:0]           ext_data_mid_byte_pins_oe_b_o,
   // data bus top byte pins
   input  wire logic [7:0]           ext_data_top_byte_pins_i,
   output logic      [7:0]           ext_data_top_byte_pins_o,
   output logic      [7:0]           ext_data_top_byte_pins_oe_b_o,
   // address low byte pins
   input  wire logic [7:0]           ext_addr_low_byte_pins_i,
   output logic      [7:0]           ext_addr_low_byte_pins_o,
   output logic      [7:0]           ext_addr_low_byte_pins_oe_b_o,
   // address mid byte pins
   input  wire logic [7:0]           ext_addr_mid_byte_pins_i,
   output logic      [7:0]           ext_addr_mid_byte_pins_o,
   output logic      [7:0]           ext_addr_mid_byte_pins_oe_b_o,
   // address upper pins, bits 16 to 20
   input  wire logic [4:0]           ext_addr_upper_pins_i,
   output logic      [4:0]           ext_addr_upper_pins_o,
   output logic      [4:0]           ext_addr_upper_pins_oe_b_o,
   // address top pins, bits 21 to 23
   input  wire logic [2:0]           ext_addr_top_pins_i,
   output logic      [2:0]           ext_addr_top_pins_o,
   output logic      [2:0]           ext_addr_top_pins_oe_b_o,
   // reload timer pins
   input  wire logic [3:0]           reload_timer_out_pins_i,
   output logic      [3:0]           reload_timer_out_pins_o,
   output logic      [3:0]           reload_timer_out_pins_oe_b_o,
   // output compare pins
   input  wire logic [7:0]           compare_out_pins_i,
   output logic      [7:0]           compare_out_pins_o,
   output logic      [7:0]           compare_out_pins_oe_b_o,
   // pulse generator pins
   input  wire logic [5:0]           pulse_gen_out_pins_i,
   output logic      [5:0]           pulse_gen_out_pins_o,
   output logic      [5:0]           pulse_gen_out_pins_oe_b_o
);

   // group a flat pin index belongs to
   function automatic logic [2:0] group_of(input int unsigned b);
      logic [2:0] g_found;
      g_found = 3'h0;
      for (int unsigned g = 0; g < GROUP_COUNT; g++)
      begin
         if (b >= GRP_LSB[g] && b < GRP_LSB[g] + GRP_WIDTH[g])
         begin
            g_found = g[2:0];
         end
      end
      return g_found;
   endfunction

   // one port group of a flat vector, zero above its width
   function automatic logic [REG_DW-1:0] group_bits(
      input logic [PIN_COUNT-1:0] vec,
      input logic [2:0]           g);
      logic [REG_DW-1:0] r;
      r = '0;
      for (int unsigned i = 0; i < REG_DW; i++)
      begin
         if (i < GRP_WIDTH[g])
         begin
            r[i] = vec[GRP_LSB[g] + i];
         end
      end
      return r;
   endfunction

   // software state
   logic [2:0]                 mode_q;
   logic [2:0]                 mode_d;
   logic [TIMER_COUNT-1:0]     timer_en_q;
   logic [TIMER_COUNT-1:0]     timer_en_d;
   logic [COMPARE_COUNT-1:0]   compare_en_q;
   logic [COMPARE_COUNT-1:0]   compare_en_d;
   logic [PULSE_COUNT-1:0]     pulse_en_q;
   logic [PULSE_COUNT-1:0]     pulse_en_d;

   logic [PIN_COUNT-1:0]       port_data_q;
   logic [PIN_COUNT-1:0]       port_data_d;
   logic [PIN_COUNT-1:0]       port_dir_q;
   logic [PIN_COUNT-1:0]       port_dir_d;

   logic [REG_DW-1:0]          rdata_q;
   logic [REG_DW-1:0]          rdata_d;
   logic [31:16]               ext_rdata_q;

   // a value flop and an enable flop per pad keep every pin output registered
   pin_slice_if #(.W(PIN_COUNT)) pins ();

   pin_slice_mux u_slice
   (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .s         (pins.mux)
   );

   // mode decode
   wire logic ext_bus_mode;
   wire logic bus8_mode;
   wire logic addr_hi_used;
   wire logic data_mid_sel;
   wire logic addr_hi_sel;

   assign ext_bus_mode = mode_q[MODE_EXT_BUS_BIT];
   assign bus8_mode    = mode_q[MODE_BUS8_BIT];
   assign addr_hi_used = mode_q[MODE_ADDR_HI_BIT];
   // 8-bit width leaves bits 16..23 free for port use
   assign data_mid_sel = ext_bus_mode && !bus8_mode;
   assign addr_hi_sel  = ext_bus_mode && addr_hi_used;

   // per-pin owner select, msb group first
   assign pins.sel =
   {
      pulse_en_q,
      compare_en_q,
      timer_en_q,
      {8{addr_hi_sel}},
      {8{ext_bus_mode}},
      {8{ext_bus_mode}},
      {8{ext_bus_mode}},
      {8{data_mid_sel}}
   };

   // function values, same order as the select
   assign pins.fn_out =
   {
      pulse_out_i,
      compare_out_i,
      timer_out_i,
      ext_addr_i[23:16],
      ext_addr_i[15:8],
      ext_addr_i[7:0],
      ext_wdata_i[31:24],
      ext_wdata_i[23:16]
   };

   // address and peripheral pins always drive when owned;
   // data pins drive only during a bus write
   assign pins.fn_drive =
   {
      {(PULSE_COUNT + COMPARE_COUNT + TIMER_COUNT){1'b1}},
      {24{1'b1}},
      {16{ext_data_drive_i}}
   };

   assign pins.port_out = port_data_q;
   assign pins.port_dir = port_dir_q;

   // pin levels in, same order as the select
   assign pins.pad_in =
   {
      pulse_gen_out_pins_i,
      compare_out_pins_i,
      reload_timer_out_pins_i,
      ext_addr_top_pins_i,
      ext_addr_upper_pins_i,
      ext_addr_mid_byte_pins_i,
      ext_addr_low_byte_pins_i,
      ext_data_top_byte_pins_i,
      ext_data_mid_byte_pins_i
   };

   // register write decode
   wire logic                   wr_mode;
   wire logic                   wr_timer;
   wire logic                   wr_compare;
   wire logic                   wr_pulse;

   wire logic [GROUP_COUNT-1:0] wr_data_grp;
   wire logic [GROUP_COUNT-1:0] wr_dir_grp;

   assign wr_mode    = reg_wr_i && (reg_addr_i == REG_MODE);
   assign wr_timer   = reg_wr_i && (reg_addr_i == REG_TIMER_EN);
   assign wr_compare = reg_wr_i && (reg_addr_i == REG_COMPARE_EN);
   assign wr_pulse   = reg_wr_i && (reg_addr_i == REG_PULSE_EN);

   for (genvar g = 0; g < GROUP_COUNT; g++)
   begin : g_wr_decode
      assign wr_data_grp[g] = reg_wr_i &&
         (reg_addr_i == REG_PORT_DATA_BASE + REG_AW'(g));
      assign wr_dir_grp[g]  = reg_wr_i &&
         (reg_addr_i == REG_PORT_DIR_BASE + REG_AW'(g));
   end

   // bits above a register's width are ignored
   assign mode_d       = wr_mode ? reg_wdata_i[2:0] : mode_q;
   assign timer_en_d   = wr_timer ? reg_wdata_i[TIMER_COUNT-1:0]
                                  : timer_en_q;
   assign compare_en_d = wr_compare ? reg_wdata_i[COMPARE_COUNT-1:0]
                                    : compare_en_q;
   assign pulse_en_d   = wr_pulse ? reg_wdata_i[PULSE_COUNT-1:0]
                                  : pulse_en_q;

   // port latches keep their value while a peripheral owns the pin
   always_comb
   begin
      port_data_d = port_data_q;
      port_dir_d  = port_dir_q;
      for (int unsigned b = 0; b < PIN_COUNT; b++)
      begin
         if (wr_data_grp[group_of(b)])
         begin
            port_data_d[b] = reg_wdata_i[b - GRP_LSB[group_of(b)]];
         end
         if (wr_dir_grp[group_of(b)])
         begin
            port_dir_d[b] = reg_wdata_i[b - GRP_LSB[group_of(b)]];
         end
      end
   end

   // register read decode
   wire logic [REG_AW-1:0] data_off;
   wire logic [REG_AW-1:0] dir_off;
   wire logic [REG_AW-1:0] lvl_off;

   wire logic              rd_data_hit;
   wire logic              rd_dir_hit;
   wire logic              rd_lvl_hit;

   wire logic [REG_DW-1:0] rd_word;

   assign data_off    = reg_addr_i - REG_PORT_DATA_BASE;
   assign dir_off     = reg_addr_i - REG_PORT_DIR_BASE;
   assign lvl_off     = reg_addr_i - REG_PIN_LEVEL_BASE;
   assign rd_data_hit = (reg_addr_i >= REG_PORT_DATA_BASE) &&
                        (data_off < REG_AW'(GROUP_COUNT));
   assign rd_dir_hit  = (reg_addr_i >= REG_PORT_DIR_BASE) &&
                        (dir_off < REG_AW'(GROUP_COUNT));
   assign rd_lvl_hit  = (reg_addr_i >= REG_PIN_LEVEL_BASE) &&
                        (lvl_off < REG_AW'(GROUP_COUNT));

   // unmapped addresses read zero
   assign rd_word =
      (reg_addr_i == REG_MODE)       ? {5'h00, mode_q} :
      (reg_addr_i == REG_TIMER_EN)   ? {4'h0, timer_en_q} :
      (reg_addr_i == REG_COMPARE_EN) ? compare_en_q :
      (reg_addr_i == REG_PULSE_EN)   ? {2'h0, pulse_en_q} :
      rd_data_hit ? group_bits(port_data_q, data_off[2:0]) :
      rd_dir_hit  ? group_bits(port_dir_q, dir_off[2:0]) :
      rd_lvl_hit  ? group_bits(pins.port_in, lvl_off[2:0]) :
      8'h00;

   // read data stands only in the cycle after the strobe
   assign rdata_d = reg_rd_i ? rd_word : 8'h00;

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         mode_q       <= MODE_RESET;
         timer_en_q   <= ENABLE_RESET[TIMER_COUNT-1:0];
         compare_en_q <= ENABLE_RESET[COMPARE_COUNT-1:0];
         pulse_en_q   <= ENABLE_RESET[PULSE_COUNT-1:0];
         port_data_q  <= PORT_DATA_RESET;
         port_dir_q   <= PORT_DIR_RESET;
         rdata_q      <= 8'h00;
         ext_rdata_q  <= 16'h0000;
      end
      else
      begin
         mode_q       <= mode_d;
         timer_en_q   <= timer_en_d;
         compare_en_q <= compare_en_d;
         pulse_en_q   <= pulse_en_d;
         port_data_q  <= port_data_d;
         port_dir_q   <= port_dir_d;
         rdata_q      <= rdata_d;
         // masked to zero where the bus does not own the pin
         ext_rdata_q  <= pins.fn_in[15:0];
      end
   end

   assign reg_rdata_o = rdata_q;
   assign ext_rdata_o = ext_rdata_q;

   // pad outputs come from the slice flops, msb group first
   assign
   {
      pulse_gen_out_pins_o,
      compare_out_pins_o,
      reload_timer_out_pins_o,
      ext_addr_top_pins_o,
      ext_addr_upper_pins_o,
      ext_addr_mid_byte_pins_o,
      ext_addr_low_byte_pins_o,
      ext_data_top_byte_pins_o,
      ext_data_mid_byte_pins_o
   } = pins.pad_out;

   // enables are active low: 0 drives the pad
   assign
   {
      pulse_gen_out_pins_oe_b_o,
      compare_out_pins_oe_b_o,
      reload_timer_out_pins_oe_b_o,
      ext_addr_top_pins_oe_b_o,
      ext_addr_upper_pins_oe_b_o,
      ext_addr_mid_byte_pins_oe_b_o,
      ext_addr_low_byte_pins_oe_b_o,
      ext_data_top_byte_pins_oe_b_o,
      ext_data_mid_byte_pins_oe_b_o
   } = pins.pad_oe_b;

endmodule // bus_and_timer_pin_mux
`default_nettype wire

// ### logic/pin_mux_pkg.sv
`default_nettype none
package pin_mux_pkg;

   // register bus shape
   localparam int unsigned REG_AW = 5;
   localparam int unsigned REG_DW = 8;

   // flat pin vector layout, lowest bit first
   localparam int unsigned PIN_COUNT      = 58;
   localparam int unsigned GROUP_COUNT    = 8;
   localparam int unsigned POS_DATA_MID   = 0;
   localparam int unsigned POS_DATA_TOP   = 8;
   localparam int unsigned POS_ADDR_LOW   = 16;
   localparam int unsigned POS_ADDR_MID   = 24;
   localparam int unsigned POS_ADDR_UPPER = 32;
   localparam int unsigned POS_ADDR_TOP   = 37;
   localparam int unsigned POS_TIMER      = 40;
   localparam int unsigned POS_COMPARE    = 44;
   localparam int unsigned POS_PULSE      = 52;
   localparam int unsigned TIMER_COUNT    = 4;
   localparam int unsigned COMPARE_COUNT  = 8;
   localparam int unsigned PULSE_COUNT    = 6;

   // port groups: two, three, four, five, six, timer, compare, pulse
   localparam int unsigned GRP_LSB [GROUP_COUNT] =
      '{0, 8, 16, 24, 32, 40, 44, 52};
   localparam int unsigned GRP_WIDTH [GROUP_COUNT] =
      '{8, 8, 8, 8, 8, 4, 8, 6};

   // register indices
   localparam logic [REG_AW-1:0] REG_MODE           = 5'h00;
   localparam logic [REG_AW-1:0] REG_TIMER_EN       = 5'h01;
   localparam logic [REG_AW-1:0] REG_COMPARE_EN     = 5'h02;
   localparam logic [REG_AW-1:0] REG_PULSE_EN       = 5'h03;
   localparam logic [REG_AW-1:0] REG_PORT_DATA_BASE = 5'h04;
   localparam logic [REG_AW-1:0] REG_PORT_DIR_BASE  = 5'h0C;
   localparam logic [REG_AW-1:0] REG_PIN_LEVEL_BASE = 5'h14;

   // mode register fields
   localparam int unsigned MODE_EXT_BUS_BIT = 0;
   localparam int unsigned MODE_BUS8_BIT    = 1;
   localparam int unsigned MODE_ADDR_HI_BIT = 2;

   // reset values
   localparam logic [2:0]         MODE_RESET     = 3'h0;
   localparam logic [REG_DW-1:0]  ENABLE_RESET   = 8'h00;
   localparam logic [PIN_COUNT-1:0] PORT_DATA_RESET = 58'h0;
   localparam logic [PIN_COUNT-1:0] PORT_DIR_RESET  = 58'h0;

endpackage
`default_nettype wire

// ### logic/pin_slice_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pin_slice_if
#(
   parameter int unsigned W = 8
);
   logic [W-1:0] sel;
   logic [W-1:0] fn_out;
   logic [W-1:0] fn_drive;
   logic [W-1:0] port_out;
   logic [W-1:0] port_dir;
   logic [W-1:0] pad_in;
   logic [W-1:0] pad_out;
   logic [W-1:0] pad_oe_b;
   logic [W-1:0] fn_in;
   logic [W-1:0] port_in;

   modport mux
   (
      input  sel, fn_out, fn_drive, port_out, port_dir, pad_in,
      output pad_out, pad_oe_b, fn_in, port_in
   );

   modport owner
   (
      output sel, fn_out, fn_drive, port_out, port_dir, pad_in,
      input  pad_out, pad_oe_b, fn_in, port_in
   );
endinterface
`default_nettype wire

// ### logic/pin_slice_mux.sv
`timescale 1ns/10ps
`default_nettype none
module pin_slice_mux
   import pin_mux_pkg::*;
(
   // clock and reset
   input  wire logic     ref_clk_i,
   input  wire logic     rst_b_i,
   // pin slice
   pin_slice_if.mux      s
);

   // per pin: function or port owns value and drive; only the function input is gated by ownership
   wire logic [$bits(s.sel)-1:0] out_d;
   wire logic [$bits(s.sel)-1:0] drive_d;

   assign out_d   = (s.sel & s.fn_out)   | (~s.sel & s.port_out);
   assign drive_d = (s.sel & s.fn_drive) | (~s.sel & s.port_dir);

   // peripheral sees zero unless it owns the pin
   assign s.fn_in   = s.sel & s.pad_in;
   // port read shows the pin level in either mode
   assign s.port_in = s.pad_in;

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s.pad_out  <= '0;
         s.pad_oe_b <= '1;
      end
      else
      begin
         s.pad_out  <= out_d;
         s.pad_oe_b <= ~drive_d;
      end
   end

endmodule // pin_slice_mux
`default_nettype wire

// ### bench/pin_mux_checker.sv
`timescale 1ns/10ps
`default_nettype none
module pin_mux_checker
   import pin_mux_pkg::*;
(
   // clock and reset
   input wire logic              ref_clk_i,
   input wire logic              rst_b_i,
   // register port
   input wire logic [REG_AW-1:0] reg_addr_i,
   input wire logic [REG_DW-1:0] reg_wdata_i,
   input wire logic              reg_wr_i,
   input wire logic              reg_rd_i,
   input wire logic [REG_DW-1:0] reg_rdata_o,
   // bus controller and peripherals
   input wire logic [23:0]       ext_addr_i,
   input wire logic [31:16]      ext_wdata_i,
   input wire logic              ext_data_drive_i,
   input wire logic [31:16]      ext_rdata_o,
   input wire logic [3:0]        timer_out_i,
   input wire logic [7:0]        compare_out_i,
   input wire logic [5:0]        pulse_out_i,
   // pads
   input wire logic [7:0]        ext_data_mid_byte_pins_i,
   input wire logic [7:0]        ext_data_top_byte_pins_i,
   input wire logic [7:0]        ext_data_mid_byte_pins_o,
   input wire logic [7:0]        ext_data_mid_byte_pins_oe_b_o,
   input wire logic [7:0]        ext_data_top_byte_pins_o,
   input wire logic [7:0]        ext_data_top_byte_pins_oe_b_o,
   input wire logic [7:0]        ext_addr_low_byte_pins_o,
   input wire logic [7:0]        ext_addr_low_byte_pins_oe_b_o,
   input wire logic [7:0]        ext_addr_mid_byte_pins_o,
   input wire logic [7:0]        ext_addr_mid_byte_pins_oe_b_o,
   input wire logic [4:0]        ext_addr_upper_pins_o,
   input wire logic [4:0]        ext_addr_upper_pins_oe_b_o,
   input wire logic [2:0]        ext_addr_top_pins_o,
   input wire logic [2:0]        ext_addr_top_pins_oe_b_o,
   input wire logic [3:0]        reload_timer_out_pins_o,
   input wire logic [3:0]        reload_timer_out_pins_oe_b_o,
   input wire logic [7:0]        compare_out_pins_o,
   input wire logic [7:0]        compare_out_pins_oe_b_o,
   input wire logic [5:0]        pulse_gen_out_pins_o,
   input wire logic [5:0]        pulse_gen_out_pins_oe_b_o
);
   logic [7:0]  shd_q [32];
   logic        ext;
   logic        hi;
   logic [57:0] sel;
   logic [57:0] fn;
   logic [57:0] drv;
   logic [57:0] pdat;
   logic [57:0] pdir;
   logic [57:0] exp_o;
   logic [57:0] exp_oe_b;
   logic [57:0] pad_o;
   logic [57:0] pad_oe_b;
   logic [57:0] want_o_q;
   logic [57:0] want_oe_b_q;
   logic [57:0] bad;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   // shadow of register writes
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         shd_q <= '{default: 8'h00};
      end
      else if (reg_wr_i)
      begin
         shd_q[reg_addr_i] <= reg_wdata_i;
      end
   end

   assign ext = shd_q[0][MODE_EXT_BUS_BIT];
   assign hi  = shd_q[0][MODE_ADDR_HI_BIT];
   assign sel = {shd_q[3][5:0], shd_q[2], shd_q[1][3:0], {8{ext & hi}},
                 {24{ext}}, {8{ext & !shd_q[0][MODE_BUS8_BIT]}}};
   assign fn  = {pulse_out_i, compare_out_i, timer_out_i, ext_addr_i,
                 ext_wdata_i};
   assign drv = {{42{1'b1}}, {16{ext_data_drive_i}}};
   assign pdat = {shd_q[11][5:0], shd_q[10], shd_q[9][3:0], shd_q[8],
                  shd_q[7], shd_q[6], shd_q[5], shd_q[4]};
   assign pdir = {shd_q[19][5:0], shd_q[18], shd_q[17][3:0], shd_q[16],
                  shd_q[15], shd_q[14], shd_q[13], shd_q[12]};
   assign exp_o    = (sel & fn) | (~sel & pdat);
   assign exp_oe_b = ~((sel & drv) | (~sel & pdir));
   assign pad_o = {pulse_gen_out_pins_o, compare_out_pins_o,
      reload_timer_out_pins_o, ext_addr_top_pins_o, ext_addr_upper_pins_o,
      ext_addr_mid_byte_pins_o, ext_addr_low_byte_pins_o,
      ext_data_top_byte_pins_o, ext_data_mid_byte_pins_o};
   assign pad_oe_b = {pulse_gen_out_pins_oe_b_o, compare_out_pins_oe_b_o,
      reload_timer_out_pins_oe_b_o, ext_addr_top_pins_oe_b_o,
      ext_addr_upper_pins_oe_b_o, ext_addr_mid_byte_pins_oe_b_o,
      ext_addr_low_byte_pins_oe_b_o, ext_data_top_byte_pins_oe_b_o,
      ext_data_mid_byte_pins_oe_b_o};

   // pads lag the expectation by their flop
   always_ff @(posedge ref_clk_i)
   begin
      want_o_q    <= exp_o;
      want_oe_b_q <= exp_oe_b;
   end

   assign bad = (pad_o ^ want_o_q) | (pad_oe_b ^ want_oe_b_q);

   a_data_mid_pins: assert property (bad[7:0] == 8'h00)
      else $error("data mid pins wrong");
   a_data_top_pins: assert property (bad[15:8] == 8'h00)
      else $error("data top pins wrong");
   a_addr_low_pins: assert property (bad[23:16] == 8'h00)
      else $error("address low pins wrong");
   a_addr_mid_pins: assert property (bad[31:24] == 8'h00)
      else $error("address mid pins wrong");
   a_addr_high_pins: assert property (
      $past(ext & hi) |-> bad[39:32] == 8'h00)
      else $error("address high pins wrong");
   a_addr_high_port: assert property (
      !(ext & hi) ##1 1'b1 |-> bad[39:32] == 8'h00)
      else $error("address high port wrong");
   a_timer_pins: assert property (bad[43:40] == 4'h0)
      else $error("timer pins wrong");
   a_compare_pins: assert property (bad[51:44] == 8'h00)
      else $error("compare pins wrong");
   a_pulse_pins: assert property (bad[57:52] == 6'h00)
      else $error("pulse pins wrong");
   a_bus_read_mask: assert property (
      ext_rdata_o == $past({ext_data_top_byte_pins_i,
      ext_data_mid_byte_pins_i} & sel[15:0])) else $error("bus read wrong");
   a_rdata_idle: assert property (
      !reg_rd_i ##1 1'b1 |-> reg_rdata_o == 8'h00)
      else $error("read data not idle");

   c_bus_write: cover property (ext && ext_data_drive_i);
   c_bus_read_hi: cover property (ext && hi && !ext_data_drive_i);
   c_timer_sel: cover property (sel[43:40] != 4'h0);
   c_reg_read: cover property (reg_rd_i ##1 reg_rdata_o != 8'h00);
endmodule // pin_mux_checker

bind bus_and_timer_pin_mux pin_mux_checker pin_mux_checker_inst (.*);
`default_nettype wire

// ### bench/board_memory_model.sv
`timescale 1ns/10ps
`default_nettype none
module board_memory_model
   import pin_mux_pkg::*;
(
   // pads as the device drives them
   input  wire logic [PIN_COUNT-1:0] pad_o_i,
   input  wire logic [PIN_COUNT-1:0] pad_oe_b_i,
   // memory read data on the data pins
   input  wire logic                 mem_drive_i,
   input  wire logic [15:0]          mem_data_i,
   // resolved levels
   output logic      [PIN_COUNT-1:0] pin_level_o
);
   // memory sits on data pins only; released pins rise to board pull-ups, except data pins while the memory drives them
   assign pin_level_o = (~pad_oe_b_i & pad_o_i) | (pad_oe_b_i &
      {{42{1'b1}}, mem_drive_i ? mem_data_i : 16'hFFFF});
endmodule // board_memory_model
`default_nettype wire

// ### bench/bus_and_timer_pin_mux_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bus_and_timer_pin_mux_tb
   import pin_mux_pkg::*;
;
   logic         ref_clk;
   logic         rst_b;
   logic [4:0]   addr;
   logic [7:0]   wdata;
   logic [7:0]   rdata;
   logic         wr;
   logic         rd;
   logic         drive;
   logic         mem_drive;
   logic [23:0]  eaddr;
   logic [31:16] ewdata;
   logic [31:16] erdata;
   logic [3:0]   tmr;
   logic [7:0]   cmp;
   logic [5:0]   pls;
   logic [15:0]  mem_data;
   logic [57:0]  po;
   logic [57:0]  poe;
   logic [57:0]  pl;
   logic [7:0]   one_hot;
   int           error_cnt;
   int           n_checks;

   bus_and_timer_pin_mux bus_and_timer_pin_mux_inst (
      .ref_clk_i(ref_clk), .rst_b_i(rst_b), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .ext_addr_i(eaddr), .ext_wdata_i(ewdata), .ext_data_drive_i(drive),
      .ext_rdata_o(erdata), .timer_out_i(tmr), .compare_out_i(cmp),
      .pulse_out_i(pls),
      .ext_data_mid_byte_pins_i(pl[7:0]), .ext_data_mid_byte_pins_o(po[7:0]),
      .ext_data_mid_byte_pins_oe_b_o(poe[7:0]),
      .ext_data_top_byte_pins_i(pl[15:8]),
      .ext_data_top_byte_pins_o(po[15:8]),
      .ext_data_top_byte_pins_oe_b_o(poe[15:8]),
      .ext_addr_low_byte_pins_i(pl[23:16]),
      .ext_addr_low_byte_pins_o(po[23:16]),
      .ext_addr_low_byte_pins_oe_b_o(poe[23:16]),
      .ext_addr_mid_byte_pins_i(pl[31:24]),
      .ext_addr_mid_byte_pins_o(po[31:24]),
      .ext_addr_mid_byte_pins_oe_b_o(poe[31:24]),
      .ext_addr_upper_pins_i(pl[36:32]), .ext_addr_upper_pins_o(po[36:32]),
      .ext_addr_upper_pins_oe_b_o(poe[36:32]),
      .ext_addr_top_pins_i(pl[39:37]), .ext_addr_top_pins_o(po[39:37]),
      .ext_addr_top_pins_oe_b_o(poe[39:37]),
      .reload_timer_out_pins_i(pl[43:40]),
      .reload_timer_out_pins_o(po[43:40]),
      .reload_timer_out_pins_oe_b_o(poe[43:40]),
      .compare_out_pins_i(pl[51:44]), .compare_out_pins_o(po[51:44]),
      .compare_out_pins_oe_b_o(poe[51:44]),
      .pulse_gen_out_pins_i(pl[57:52]), .pulse_gen_out_pins_o(po[57:52]),
      .pulse_gen_out_pins_oe_b_o(poe[57:52])
   );

   board_memory_model board_memory_model_inst (
      .pad_o_i(po), .pad_oe_b_i(poe), .mem_drive_i(mem_drive),
      .mem_data_i(mem_data), .pin_level_o(pl)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic check(input string what, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   task automatic port_cfg(input logic [4:0] g, input logic [7:0] d, o);
      wr_reg(REG_PORT_DATA_BASE + g, d);
      wr_reg(REG_PORT_DIR_BASE + g, o);
   endtask

   task automatic rd_reg(input string what, input logic [4:0] a,
                         input logic [7:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      check(what, {8'h00, rdata}, {8'h00, e});
   endtask

   // wr_reg ends on the register edge; pads need one pad flop edge, and the second edge is spare
   task automatic settle;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask

   task automatic conclude;
      if (error_cnt == 0 && n_checks > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial
   begin
      repeat (3000) @(posedge ref_clk);
      error_cnt++;
      conclude;
   end

   initial
   begin
      {rst_b, wr, rd, drive, mem_drive} = 5'h00;
      {addr, wdata, eaddr, ewdata, tmr, cmp, pls, mem_data} = '0;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      settle;
      check("reset pads", {15'h0, &poe & ~|po}, 16'h0001);
      rd_reg("mode", REG_MODE, 8'h00);
      rd_reg("unmapped", 5'h1C, 8'h00);
      port_cfg(5'h0, 8'h81, 8'hFF);
      port_cfg(5'h1, 8'h3C, 8'h0F);
      port_cfg(5'h2, 8'hA5, 8'hFF);
      port_cfg(5'h4, 8'hC3, 8'hFF);
      eaddr  <= 24'h5AC396;
      ewdata <= 16'hBEEF;
      drive  <= 1'b1;
      settle;
      check("addr low port", {po[23:16], poe[23:16]}, 16'hA500);
      check("data top port", {po[15:8], poe[15:8]}, 16'h3CF0);
      rd_reg("data top level", REG_PIN_LEVEL_BASE + 5'h1, 8'hFC);
      wr_reg(REG_MODE, 8'h01);
      settle;
      check("addr low bus", {po[23:16], poe[23:16]}, 16'h9600);
      check("addr mid bus", {po[31:24], poe[31:24]}, 16'hC300);
      check("addr high port", {po[39:32], poe[39:32]}, 16'hC300);
      check("data mid bus", {po[7:0], poe[7:0]}, 16'hEF00);
      check("data top bus", {po[15:8], poe[15:8]}, 16'hBE00);
      @(posedge ref_clk);
      drive     <= 1'b0;
      mem_drive <= 1'b1;
      mem_data  <= 16'h1234;
      settle;
      check("data release", poe[15:0], 16'hFFFF);
      check("bus read", erdata, 16'h1234);
      wr_reg(REG_MODE, 8'h05);
      settle;
      check("addr high bus", {po[39:32], poe[39:32]}, 16'h5A00);
      wr_reg(REG_MODE, 8'h03);
      settle;
      check("data mid 8bit", {po[7:0], poe[7:0]}, 16'h8100);
      check("bus read 8bit", erdata, 16'h1200);
      check("addr high idle", {po[39:32], poe[39:32]}, 16'hC300);
      wr_reg(REG_MODE, 8'hF8);
      rd_reg("mode narrow", REG_MODE, 8'h00);
      settle;
      check("addr mid port", {po[31:24], poe[31:24]}, 16'h00FF);
      check("bus read off", erdata, 16'h0000);
      @(posedge ref_clk);
      {tmr, cmp, pls} <= '1;
      for (int i = 0; i < 8; i++)
      begin
         one_hot = 8'h01 << i;
         wr_reg(REG_TIMER_EN, one_hot);
         wr_reg(REG_COMPARE_EN, one_hot);
         wr_reg(REG_PULSE_EN, one_hot);
         settle;
         check("timer pins", {8'h00, po[43:40], poe[43:40]},
               {8'h00, one_hot[3:0], ~one_hot[3:0]});
         check("compare pins", {po[51:44], poe[51:44]},
               {one_hot, ~one_hot});
         check("pulse pins", {4'h0, po[57:52], poe[57:52]},
               {4'h0, one_hot[5:0], ~one_hot[5:0]});
      end
      port_cfg(5'h5, 8'h0A, 8'h0F);
      wr_reg(REG_TIMER_EN, 8'h05);
      tmr <= 4'h0;
      settle;
      check("timer mixed", {8'h00, po[43:40], poe[43:40]}, 16'h00A0);
      rd_reg("timer enable", REG_TIMER_EN, 8'h05);
      @(posedge ref_clk);
      rst_b <= 1'b0;
      @(posedge ref_clk);
      #1;
      check("reset again", {15'h0, &poe & ~|po}, 16'h0001);
      @(posedge ref_clk);
      rst_b <= 1'b1;
      rd_reg("mode cleared", REG_MODE, 8'h00);
      conclude;
   end
endmodule // bus_and_timer_pin_mux_tb
`default_nettype wire
